// [design/tpo_top.sv]
// teleprinter serial output control with wishbone status and control access
`timescale 1ns/10ps
module tpo_top
  import tpo_pkg::*;
#(
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  // processor side
  input  wire logic        io_transfer_instruction,
  input  wire logic [0:17] memory_buffer_register,
  input  wire logic [7:0]  arithmetic_register,
  input  wire logic        first_exec_pulse,
  input  wire logic        second_exec_pulse,
  input  wire logic        third_exec_pulse,
  input  wire logic        kbd_receiving,
  output logic             interrupt_request,
  output logic             skip_request_bus,
  // line side
  output logic             printer_line,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // --------------------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------------------
  tpo_ctl_if ctl ();

  tpo_bit_clock #(
    .BIT_CYCLES_P (BIT_CYCLES_P)
  ) u_bit_clock (
    .clk  (clk),
    .nrst (nrst),
    .ctl  (ctl.clk_gen)
  );

  tpo_dev_select u_dev_select (
    .ctl (ctl.decoder)
  );

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  tpo_core_s st_ff;
  tpo_core_s nxt_st;

  logic       sel;
  logic       clear_done_flag_cmd;
  logic       load_character_pulse;
  logic       skip_on_done_cmd;
  logic       bit_tick;
  logic       shift_pulse;
  logic       end_of_char_detect;
  logic       wb_req;
  logic       wb_wr;
  logic [7:0] status_bits;

  assign ctl.dev_field = memory_buffer_register[6:11];
  // bit clock stops while the keyboard receives in half duplex
  assign ctl.run = st_ff.full_duplex | ~kbd_receiving;

  assign sel      = io_transfer_instruction & ctl.printer_select;
  assign bit_tick = ctl.tick;

  // --------------------------------------------------------------------------
  // instruction micro-operations
  // --------------------------------------------------------------------------
  // a load-and-send word carries both bit 16 and bit 15, so one instruction
  // clears the flag in the second period and loads in the third
  assign clear_done_flag_cmd  = second_exec_pulse & memory_buffer_register[16] & sel;
  assign load_character_pulse = third_exec_pulse & memory_buffer_register[15] & sel;
  assign skip_on_done_cmd     = first_exec_pulse & memory_buffer_register[17] & sel;

  // --------------------------------------------------------------------------
  // serial sequencing
  // --------------------------------------------------------------------------
  assign shift_pulse = bit_tick & st_ff.active;
  // stop bit alone in bit 7, everything above it and the stop cell empty
  assign end_of_char_detect = st_ff.active & st_ff.sr[7] & ~st_ff.stop_cell
                            & ~st_ff.shift_en & (st_ff.sr[0:6] == 7'h00);

  assign wb_req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  // writes commit on the edge at which the master sees ack, not when taken
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & st_ff.ack;

  always_comb
  begin
    status_bits                 = 8'h00;
    status_bits[ST_FLAG_BIT]    = st_ff.done_flag;
    status_bits[ST_START_BIT]   = st_ff.start;
    status_bits[ST_ACTIVE_BIT]  = st_ff.active;
    status_bits[ST_EN_BIT]      = st_ff.shift_en;
    status_bits[ST_STOP_BIT]    = st_ff.stop_cell;
    status_bits[ST_LINE_BIT]    = st_ff.line_mark;
    status_bits[ST_RUN_BIT]     = ctl.run;
  end

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.skip = 1'b0;

    // ------------------------------------------------------------------------
    // bit clock stepping: enable -> start -> active -> shifts
    // ------------------------------------------------------------------------
    if (bit_tick)
    begin
      if (st_ff.shift_en && !st_ff.start)
      begin
        nxt_st.start = 1'b1;
      end
      if (st_ff.start && !st_ff.active)
      begin
        nxt_st.active    = 1'b1;
        nxt_st.line_mark = 1'b0;
      end
    end

    if (shift_pulse)
    begin
      // low-order bit leaves onto the line, mark for one
      nxt_st.line_mark = st_ff.sr[7];
      nxt_st.sr        = {st_ff.stop_cell, st_ff.sr[0:6]};
      nxt_st.stop_cell = st_ff.shift_en;
      nxt_st.shift_en  = 1'b0;
      if (end_of_char_detect)
      begin
        nxt_st.start      = 1'b0;
        nxt_st.active     = 1'b0;
        nxt_st.char_count = st_ff.char_count + 16'h0001;
      end
    end

    // ------------------------------------------------------------------------
    // parallel load from the processor
    // ------------------------------------------------------------------------
    if (load_character_pulse)
    begin
      nxt_st.sr        = arithmetic_register;
      nxt_st.shift_en  = 1'b1;
      nxt_st.stop_cell = 1'b1;
    end

    // ------------------------------------------------------------------------
    // done flag: the end of a character wins over a clear in the same cycle
    // ------------------------------------------------------------------------
    if (clear_done_flag_cmd)
    begin
      nxt_st.done_flag = 1'b0;
    end
    if (shift_pulse && end_of_char_detect)
    begin
      nxt_st.done_flag = 1'b1;
    end

    nxt_st.irq = nxt_st.done_flag;
    // skip samples the flag as it stands when the first period starts
    if (skip_on_done_cmd && st_ff.done_flag)
    begin
      nxt_st.skip = 1'b1;
    end

    // ------------------------------------------------------------------------
    // wishbone slave: one-cycle answer, unmapped reads return zero
    // ------------------------------------------------------------------------
    nxt_st.ack = wb_req;
    if (wb_req)
    begin
      case (wb_adr_i)
        ADDR_CTRL:
        begin
          nxt_st.rdata = {31'h000_0000, st_ff.full_duplex};
        end
        ADDR_STATUS:
        begin
          nxt_st.rdata = {24'h00_0000, status_bits};
        end
        ADDR_SHIFT:
        begin
          nxt_st.rdata = {22'h0_0000, st_ff.shift_en, st_ff.stop_cell, st_ff.sr};
        end
        ADDR_COUNT:
        begin
          nxt_st.rdata = {16'h0000, st_ff.char_count};
        end
        default:
        begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (wb_wr && wb_sel_i[0])
    begin
      case (wb_adr_i)
        ADDR_CTRL:
        begin
          nxt_st.full_duplex = wb_dat_i[CTRL_DUPLEX_BIT];
        end
        ADDR_COUNT:
        begin
          // counter is cleared by any write to its low byte
          nxt_st.char_count = 16'h0000;
        end
        default:
        begin
          nxt_st.full_duplex = st_ff.full_duplex;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff             <= '0;
      st_ff.line_mark   <= RST_LINE_MARK;
      st_ff.full_duplex <= RST_FULL_DUPLEX;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign interrupt_request = st_ff.irq;
  assign skip_request_bus  = st_ff.skip;
  assign printer_line      = st_ff.line_mark;
  assign wb_dat_o          = st_ff.rdata;
  assign wb_ack_o          = st_ff.ack;

endmodule : tpo_top

// [design/tpo_pkg.sv]
// shared constants, types and helpers for the teleprinter serial output block
// ----------------------------------------------------------------------------
// Functional notes
// - load-and-send is clear-flag plus load-and-print
// - load takes 8-bit character in parallel
// - start space, eight bits, then stop marks
// - one character takes about 100 ms
// - done flag feeds interrupt and skip logic
// - select decoded from instruction bits 06-11
// - second exec pulse with bit 16 clears flag
// - third exec pulse with bit 15 loads character
// - load sets enable, stop, captures bits 0-7
// - bit clock runs full duplex or keyboard idle
// - bit clock runs at 110 pulses per second
// - start, active, then shift on third clock
// - active puts start space on the line
// - shift moves enable, stop, bits downward
// - low-order bit shifts out onto the line
// - stop bit alone in bit 7: end detect
// - tenth shift ends character, sets done flag
// - done flag drives interrupt request
// - skip-on-done drives skip request when flag set
// - skip test at first exec pulse with bit 17
// ----------------------------------------------------------------------------
package tpo_pkg;

  // ------------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned BIT_RATE_PPS = 110;
  // period rounded down so the rate never falls below the line's rate
  localparam int unsigned BIT_CYCLES   = CLK_HZ / BIT_RATE_PPS;

  // ------------------------------------------------------------------------
  // device code and register map
  // ------------------------------------------------------------------------
  localparam logic [5:0] DEV_CODE    = 6'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SHIFT  = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0c;

  localparam int unsigned CTRL_DUPLEX_BIT = 0;
  localparam int unsigned ST_FLAG_BIT     = 0;
  localparam int unsigned ST_START_BIT    = 1;
  localparam int unsigned ST_ACTIVE_BIT   = 2;
  localparam int unsigned ST_EN_BIT       = 3;
  localparam int unsigned ST_STOP_BIT     = 4;
  localparam int unsigned ST_LINE_BIT     = 5;
  localparam int unsigned ST_RUN_BIT      = 6;

  // ------------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------------
  localparam logic RST_LINE_MARK   = 1'b1;
  localparam logic RST_FULL_DUPLEX = 1'b0;

  typedef enum logic [1:0] {
    TPO_IDLE   = 2'b00,
    TPO_WAIT   = 2'b01,
    TPO_START  = 2'b11,
    TPO_ACTIVE = 2'b10
  } tpo_phase_e;

  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } tpo_clk_s;

  typedef struct packed {
    logic [0:7]  sr;
    logic        shift_en;
    logic        stop_cell;
    logic        start;
    logic        active;
    logic        line_mark;
    logic        done_flag;
    logic        irq;
    logic        skip;
    logic        full_duplex;
    logic [15:0] char_count;
    logic        ack;
    logic [31:0] rdata;
  } tpo_core_s;

  function automatic logic is_dev(input logic [5:0] field);
    is_dev = (field == DEV_CODE);
  endfunction : is_dev

endpackage : tpo_pkg

// [design/tpo_ctl_if.sv]
// carrier between the core, its bit clock and its device select decode
`timescale 1ns/10ps
interface tpo_ctl_if;
  logic       run;
  logic       tick;
  logic [5:0] dev_field;
  logic       printer_select;

  modport clk_gen (input run, output tick);
  modport decoder (input dev_field, output printer_select);
  modport core    (output run, output dev_field, input tick, input printer_select);
endinterface : tpo_ctl_if

// [design/tpo_bit_clock.sv]
// baud-rate bit clock: one-cycle tick per code unit while enabled
`timescale 1ns/10ps
module tpo_bit_clock
  import tpo_pkg::*;
#(
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES
)(
  input  wire logic clk,
  input  wire logic nrst,
  tpo_ctl_if.clk_gen ctl
);

  tpo_clk_s st_ff;
  tpo_clk_s nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    // stopped clock restarts a full unit later, like the gated original
    if (!ctl.run)
    begin
      nxt_st.count = 32'h0000_0000;
    end
    else if (st_ff.count >= BIT_CYCLES_P - 1)
    begin
      nxt_st.count = 32'h0000_0000;
      nxt_st.tick  = 1'b1;
    end
    else
    begin
      nxt_st.count = st_ff.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign ctl.tick = st_ff.tick;

endmodule : tpo_bit_clock

// [design/tpo_dev_select.sv]
// device select decode of the instruction's device field
`timescale 1ns/10ps
module tpo_dev_select
  import tpo_pkg::*;
(
  tpo_ctl_if.decoder ctl
);

  assign ctl.printer_select = is_dev(ctl.dev_field);

endmodule : tpo_dev_select

// [verif/tpo_chk_sva.sv]
// concurrent checks on the teleprinter output block ports
`timescale 1ns/10ps
module tpo_chk
  import tpo_pkg::*;
#(
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES
)(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        io_transfer_instruction,
  input wire logic [0:17] memory_buffer_register,
  input wire logic        first_exec_pulse,
  input wire logic        second_exec_pulse,
  input wire logic        interrupt_request,
  input wire logic        skip_request_bus,
  input wire logic        printer_line,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  logic sel_w;
  logic clr_w;
  assign sel_w = io_transfer_instruction && (memory_buffer_register[6:11] == DEV_CODE);
  assign clr_w = second_exec_pulse && sel_w && memory_buffer_register[16];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_skip_once;
    skip_request_bus |=> !skip_request_bus;
  endproperty
  a_skip_once: assert property (p_skip_once) else $error("skip longer than one cycle");
  property p_skip_cause;
    skip_request_bus |-> $past(first_exec_pulse && sel_w && memory_buffer_register[17]
                               && interrupt_request);
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("skip without cause");
  property p_clear;
    clr_w |=> !interrupt_request;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_flag_hold;
    interrupt_request && !clr_w |=> interrupt_request;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_stop_mark;
    $rose(interrupt_request) |-> printer_line && $past(printer_line);
  endproperty
  a_stop_mark: assert property (p_stop_mark) else $error("flag set off stop mark");
  // stalls only stretch a unit, so six stable edges always hold at eight
  property p_unit;
    $changed(printer_line) |=> $stable(printer_line) [*6];
  endproperty
  a_unit: assert property (p_unit) else $error("code unit too short");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack late");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("bus ack held");
  c_skip: cover property (skip_request_bus);
  c_done: cover property ($rose(interrupt_request));
  c_clear: cover property (clr_w && interrupt_request);
endmodule : tpo_chk

bind tpo_top tpo_chk #(.BIT_CYCLES_P(BIT_CYCLES_P)) u_chk (
  .clk(clk), .nrst(nrst), .io_transfer_instruction(io_transfer_instruction),
  .memory_buffer_register(memory_buffer_register), .first_exec_pulse(first_exec_pulse),
  .second_exec_pulse(second_exec_pulse), .interrupt_request(interrupt_request),
  .skip_request_bus(skip_request_bus), .printer_line(printer_line),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// [verif/tpo_line_model.sv]
// printer line receiver: decodes one character per frame
`timescale 1ns/10ps
module tpo_line_model #(
  parameter int unsigned BIT_CYCLES_P = 8
)(
  input  wire logic       clk,
  input  wire logic       line,
  output logic      [7:0] char_o,
  output logic            got,
  output logic            frame_ok
);
  initial
  begin
    got = 1'b0;
    char_o = '0;
    frame_ok = 1'b0;
    forever
    begin
      @(negedge line);
      // sample mid unit so edge jitter of a cycle is harmless
      repeat (BIT_CYCLES_P / 2) @(posedge clk);
      frame_ok = !line;
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES_P) @(posedge clk);
        char_o[i] = line;
      end
      repeat (BIT_CYCLES_P) @(posedge clk);
      frame_ok = frame_ok && line;
      got = ~got;
    end
  end
endmodule : tpo_line_model

// [verif/tb_top.sv]
// self-checking bench for the teleprinter output block
`timescale 1ns/10ps
module tb_top;
  import tpo_pkg::*;
  localparam int unsigned BC = 8;
  logic        clk = 1'b0;
  logic        nrst, io, p1, p2, p3, kbd, irq, skip, line, cyc, stb, we, ack, got, fok, sk;
  logic [0:17] mb;
  logic [7:0]  ar, adr, ch;
  logic [3:0]  sel;
  logic [31:0] dw, dr, rd;
  int          miscompares, n_checks;

  tpo_top #(.BIT_CYCLES_P(BC)) u_dut (.clk(clk), .nrst(nrst), .io_transfer_instruction(io),
    .memory_buffer_register(mb), .arithmetic_register(ar), .first_exec_pulse(p1),
    .second_exec_pulse(p2), .third_exec_pulse(p3), .kbd_receiving(kbd),
    .interrupt_request(irq), .skip_request_bus(skip), .printer_line(line), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack));
  tpo_line_model #(.BIT_CYCLES_P(BC)) u_line (.clk(clk), .line(line), .char_o(ch), .got(got),
    .frame_ok(fok));

  always #2.5 clk = ~clk;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= 4'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 20)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : wb

  // op bits map to instruction bits 15, 16, 17
  task iot_op(input logic [2:0] op, input logic [5:0] dev);
    io <= 1'b1;
    mb <= {6'o70, dev, 3'b000, op};
    p1 <= 1'b1;
    @(posedge clk);
    p1 <= 1'b0;
    p2 <= 1'b1;
    @(posedge clk);
    sk = skip;
    p2 <= 1'b0;
    p3 <= 1'b1;
    @(posedge clk);
    p3 <= 1'b0;
    io <= 1'b0;
    @(posedge clk);
  endtask : iot_op

  task fin(input logic [7:0] c, input logic g0, input logic tm);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (tm)
      chk("frame time", 1, (n >= 10 * BC && n <= 12 * BC + 4));
    chk("character", {2'b11, c}, {got ^ g0, fok, ch});
    if (n >= 400)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : fin

  task send(input logic [7:0] c, input logic [2:0] op);
    logic g0;
    g0 = got;
    ar <= c;
    iot_op(op, DEV_CODE);
    fin(c, g0, 1'b1);
  endtask : send

  initial
  begin
    logic g0;
    {nrst, io, mb, ar, p1, p2, p3, kbd, cyc, stb, we, adr, sel, dw} = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    chk("reset outputs", 3'b100, {line, irq, skip});
    nrst <= 1'b1;
    @(posedge clk);
    // ------------------------------------------------------------------
    // reset state and idle skip
    // ------------------------------------------------------------------
    wb(1'b0, ADDR_STATUS, 0);
    chk("status", 32'h0000_0060, rd);
    wb(1'b0, 8'h10, 0);
    chk("unmapped read", 0, rd);
    iot_op(3'b001, DEV_CODE);
    chk("skip with flag clear", 0, sk);
    $display("test reset done");
    // ------------------------------------------------------------------
    // characters, skip and select
    // ------------------------------------------------------------------
    for (int i = 0; i < 8; i++)
    begin
      send(8'h01 << i ^ 8'ha5, 3'b110);
      iot_op(3'b001, DEV_CODE);
      chk("skip with flag set", 1, sk);
      iot_op(3'b001, DEV_CODE ^ 6'h01);
      chk("skip other device", 0, sk);
    end
    iot_op(3'b010, DEV_CODE);
    chk("flag after clear", 0, irq);
    send(8'h3c, 3'b100);
    wb(1'b0, ADDR_COUNT, 0);
    chk("character count", 32'h0000_0009, rd);
    wb(1'b1, ADDR_COUNT, 0);
    $display("test characters done");
    // ------------------------------------------------------------------
    // bit clock held off while keyboard receives
    // ------------------------------------------------------------------
    g0 = got;
    kbd <= 1'b1;
    ar <= 8'h5a;
    iot_op(3'b110, DEV_CODE);
    repeat (4 * BC) @(posedge clk);
    chk("stalled line", 2'b10, {line, irq});
    wb(1'b0, ADDR_STATUS, 0);
    chk("stalled status", 32'h0000_0038, rd);
    wb(1'b0, ADDR_SHIFT, 0);
    chk("loaded shift cells", 32'h0000_035a, rd);
    wb(1'b1, ADDR_CTRL, 32'h0000_0001);
    fin(8'h5a, g0, 1'b0);
    wb(1'b0, ADDR_CTRL, 0);
    chk("ctrl", 32'h0000_0001, rd);
    wb(1'b0, ADDR_COUNT, 0);
    chk("count after clear", 32'h0000_0001, rd);
    $display("test stall done");
    end_of_test();
  end
endmodule : tb_top
